//--- adcsum_consts.vh
// register map, field positions, reset values and timing constants of the converter control block
`ifndef ADCSUM_CONSTS_VH
`define ADCSUM_CONSTS_VH

// ----------------
// register offsets on the special function register bus
// ----------------
`define ADCSUM_ADDR_RES_LO 8'hd9
`define ADCSUM_ADDR_RES_MID 8'hda
`define ADCSUM_ADDR_RES_HI 8'hdb
`define ADCSUM_ADDR_FRONT 8'hdc
`define ADCSUM_ADDR_FMT 8'hdd
`define ADCSUM_ADDR_DEC_LO 8'hde
`define ADCSUM_ADDR_DEC_HI 8'hdf
`define ADCSUM_ADDR_SSC 8'he1
`define ADCSUM_ADDR_SUM0 8'he2
`define ADCSUM_ADDR_SUM1 8'he3
`define ADCSUM_ADDR_SUM2 8'he4
`define ADCSUM_ADDR_SUM3 8'he5

// ----------------
// reset values and writable masks
// ----------------
`define ADCSUM_RST_BYTE 8'h00
`define ADCSUM_RST_FRONT 8'h30
`define ADCSUM_RST_DEC_LO 8'h1b
`define ADCSUM_RST_DEC_HI 3'h6
`define ADCSUM_MASK_FRONT 8'h7f
`define ADCSUM_GAIN_UNITY 8'h01

// ----------------
// field positions
// ----------------
`define ADCSUM_FRONT_BOD 6
`define ADCSUM_FRONT_INTERNAL_REFERENCE_ENABLE 5
`define ADCSUM_FRONT_REFERENCE_LEVEL_SELECT 4
`define ADCSUM_FRONT_INPUT_BUFFER_ENABLE 3
`define ADCSUM_GAIN_HI 2
`define ADCSUM_GAIN_LO 0
`define ADCSUM_FMT_POL 6
`define ADCSUM_FMT_SM_HI 5
`define ADCSUM_FMT_SM_LO 4
`define ADCSUM_CAL_HI 2
`define ADCSUM_CAL_LO 0
`define ADCSUM_DEC_HI_MSB 2
`define ADCSUM_SSC_MODE_HI 7
`define ADCSUM_SSC_MODE_LO 6
`define ADCSUM_SSC_CNT_HI 5
`define ADCSUM_SSC_CNT_LO 3
`define ADCSUM_SSC_SHF_HI 2
`define ADCSUM_SSC_SHF_LO 0

// ----------------
// codes and timing
// ----------------
`define ADCSUM_MODE_CPU 2'b00
`define ADCSUM_MODE_SUM 2'b01
`define ADCSUM_MODE_SHIFT 2'b10
`define ADCSUM_MODE_SUMSHIFT 2'b11
`define ADCSUM_CAL_NONE 3'h0
`define ADCSUM_CAL_LAST 3'h5
`define ADCSUM_OVERSAMPLE 7'h40
`define ADCSUM_SHIFT_CYCLES 3'h4
`define ADCSUM_UNI_ZERO 24'h000000
`define ADCSUM_UNI_FULL 24'hffffff

`endif

//--- adcsum_tick_div.v
// programmable period divider that emits a one-cycle enable pulse
`timescale 1ns/1ps

module adcsum_tick_div #(
    parameter W = 8
) (
    input wire clk_sys,
    input wire rst,
    input wire en,
    input wire [W-1:0] period,
    output wire tick
);
    reg [W-1:0] count_q;
    wire last;

    // a period of zero behaves as one so the chain never stalls
    assign last = (period == {W{1'b0}}) || (count_q >= period - 1'b1);
    assign tick = en & last;

    // count enabled cycles, wrap on the last one
    always @(posedge clk_sys) begin
        if (rst) begin
            count_q <= {W{1'b0}};
        end else if (en) begin
            count_q <= last ? {W{1'b0}} : count_q + 1'b1;
        end
    end
endmodule

//--- adcsum_accum.v
// 32-bit summation and shift engine
`timescale 1ns/1ps
`include "adcsum_consts.vh"

module adcsum_accum (
    input wire clk_sys,
    input wire rst,
    input wire power_down,
    input wire [1:0] mode,
    input wire [2:0] cnt_code,
    input wire [2:0] shf_code,
    input wire bipolar,
    input wire clear,
    input wire shift_go,
    input wire cpu_add,
    input wire [31:0] cpu_value,
    input wire adc_add,
    input wire [23:0] adc_value,
    output wire [31:0] acc,
    output wire busy,
    output reg done
);
    localparam ST_IDLE = 2'b01;
    localparam ST_SHIFT = 2'b10;

    reg [1:0] st_q;
    reg [31:0] acc_q;
    reg [8:0] cnt_q;
    reg [2:0] cyc_q;
    wire [31:0] adc_ext;
    wire [8:0] target;
    wire [3:0] shamt;
    wire signed [31:0] ash;
    wire [31:0] shifted;

    // ----------------
    // operand shaping
    // ----------------
    assign adc_ext = bipolar ? {{8{adc_value[23]}}, adc_value}
                             : {8'h00, adc_value};
    assign target = 9'h002 << cnt_code;
    assign shamt = {1'b0, shf_code} + 4'h1;
    // kept in its own wire so the shift stays arithmetic
    assign ash = $signed(acc_q) >>> shamt;
    assign shifted = bipolar ? ash : (acc_q >> shamt);
    assign acc = acc_q;
    assign busy = (st_q == ST_SHIFT);

    // accumulate, count and shift; powered down means held at zero
    always @(posedge clk_sys) begin
        if (rst || power_down) begin
            st_q <= ST_IDLE;
            acc_q <= 32'h00000000;
            cnt_q <= 9'h000;
            cyc_q <= 3'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (clear) begin
                        acc_q <= 32'h00000000;
                        cnt_q <= 9'h000;
                    end else if (shift_go) begin
                        st_q <= ST_SHIFT;
                        cyc_q <= 3'h0;
                    end else if (cpu_add && mode == `ADCSUM_MODE_CPU) begin
                        acc_q <= acc_q + cpu_value;
                    end else if (adc_add && mode[0]) begin
                        acc_q <= acc_q + adc_ext;
                        if (cnt_q + 9'h001 == target) begin
                            cnt_q <= 9'h000;
                            if (mode == `ADCSUM_MODE_SUMSHIFT) begin
                                st_q <= ST_SHIFT;
                                cyc_q <= 3'h0;
                            end else begin
                                done <= 1'b1;
                            end
                        end else begin
                            cnt_q <= cnt_q + 9'h001;
                        end
                    end
                end
                ST_SHIFT: begin
                    // the shift lands on the fourth cycle of the state
                    if (cyc_q == `ADCSUM_SHIFT_CYCLES - 3'h1) begin
                        acc_q <= shifted;
                        st_q <= ST_IDLE;
                        done <= (mode == `ADCSUM_MODE_SUMSHIFT);
                    end else begin
                        cyc_q <= cyc_q + 3'h1;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

//--- adcsum_top.v
// converter control registers, result holding and summation unit on the register bus
`timescale 1ns/1ps
`include "adcsum_consts.vh"

// What this block does
// - three result bytes hold the sample; reading low byte clears converter interrupt
// - open input detect bit turns on both test current sources together
// - front control resets to 30h: reference on, high level, buffer off, unity
// - gain code n selects amplifier gain of two to the power n
// - format bit: bipolar two's complement, or unipolar with negatives clamped to zero
// - settling field selects auto, fast, second or third order filter
// - writing calibration code starts calibration; field always reads zero
// - eleven-bit decimation ratio sets result rate with clock divider and 64
// - summation unit is powered down whenever converter is powered down
// - writing zero to summation control clears the whole accumulator unless a shift is in progress
// - bipolar results are sign extended to 32 bits before adding
// - mode 00: processor value is added when lowest sum byte is written
// - mode 01: each converter result is added and the count advances
// - mode 10: accumulator shifts right by programmed count in four cycles
// - mode 11: sum results for programmed count, then shift the total
// - addition count code n means two to the power n plus one
// - summation complete raises masked interrupt; lowest sum byte read clears it
// - shift code n shifts right by n plus one bit positions
// - in mode 00, writing lowest sum byte adds it and the three staged upper bytes into accumulator
module adcsum_top (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output wire sfr_hit,
    input wire [7:0] analog_clk_div,
    input wire adc_power_down,
    input wire sum_irq_mask,
    input wire [23:0] mod_result,
    input wire mod_result_valid,
    output wire conv_tick,
    output wire open_input_pos_current_en,
    output wire open_input_neg_current_en,
    output wire internal_reference_enable,
    output wire reference_level_select,
    output wire input_buffer_enable,
    output reg [7:0] gain_factor,
    output wire result_format_select,
    output wire [1:0] settling_select,
    output reg calibration_start,
    output reg [2:0] calibration_code,
    output wire [10:0] decim_ratio,
    output wire adc_irq,
    output wire sum_irq,
    output wire sum_busy
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg [7:0] front_q;
    reg result_format_q;
    reg [1:0] settling_q;
    reg [7:0] decim_lo_q;
    reg [2:0] decim_hi_q;
    reg [7:0] ssc_q;
    reg [7:0] stage1_q;
    reg [7:0] stage2_q;
    reg [7:0] stage3_q;
    reg [23:0] result_q;
    reg adc_irq_q;
    reg sum_pend_q;
    reg [7:0] rdata_d;

    wire wr_fmt;
    wire wr_ssc;
    wire wr_sum0;
    wire rd_res_lo;
    wire rd_sum0;
    wire capture;
    wire [23:0] result_fmt;
    wire [31:0] acc;
    wire sum_done;
    wire tick_aclk;
    wire tick_os;
    wire [8:0] aclk_period;
    wire [2:0] cal_wr;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // strobes for registers whose access has a side effect
    assign wr_fmt = sfr_wr && (sfr_addr == `ADCSUM_ADDR_FMT);
    assign wr_ssc = sfr_wr && (sfr_addr == `ADCSUM_ADDR_SSC);
    assign wr_sum0 = sfr_wr && (sfr_addr == `ADCSUM_ADDR_SUM0);
    assign rd_res_lo = sfr_rd && (sfr_addr == `ADCSUM_ADDR_RES_LO);
    assign rd_sum0 = sfr_rd && (sfr_addr == `ADCSUM_ADDR_SUM0);
    assign cal_wr = sfr_wdata[`ADCSUM_CAL_HI:`ADCSUM_CAL_LO];

    // address hit covers every mapped offset of this block
    assign sfr_hit = (sfr_addr >= `ADCSUM_ADDR_RES_LO && sfr_addr <= `ADCSUM_ADDR_DEC_HI)
                  || (sfr_addr >= `ADCSUM_ADDR_SSC && sfr_addr <= `ADCSUM_ADDR_SUM3);

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    // software-written settings; reserved bits are dropped on write
    always @(posedge clk_sys) begin
        if (rst) begin
            front_q <= `ADCSUM_RST_FRONT;
            result_format_q <= 1'b0;
            settling_q <= 2'b00;
            decim_lo_q <= `ADCSUM_RST_DEC_LO;
            decim_hi_q <= `ADCSUM_RST_DEC_HI;
            ssc_q <= `ADCSUM_RST_BYTE;
            stage1_q <= `ADCSUM_RST_BYTE;
            stage2_q <= `ADCSUM_RST_BYTE;
            stage3_q <= `ADCSUM_RST_BYTE;
        end else if (sfr_wr) begin
            case (sfr_addr)
                `ADCSUM_ADDR_FRONT: begin
                    front_q <= sfr_wdata & `ADCSUM_MASK_FRONT;
                end
                `ADCSUM_ADDR_FMT: begin
                    result_format_q <= sfr_wdata[`ADCSUM_FMT_POL];
                    settling_q <= sfr_wdata[`ADCSUM_FMT_SM_HI:`ADCSUM_FMT_SM_LO];
                end
                `ADCSUM_ADDR_DEC_LO: begin
                    decim_lo_q <= sfr_wdata;
                end
                `ADCSUM_ADDR_DEC_HI: begin
                    decim_hi_q <= sfr_wdata[`ADCSUM_DEC_HI_MSB:0];
                end
                `ADCSUM_ADDR_SSC: begin
                    ssc_q <= sfr_wdata;
                end
                `ADCSUM_ADDR_SUM1: begin
                    stage1_q <= sfr_wdata;
                end
                `ADCSUM_ADDR_SUM2: begin
                    stage2_q <= sfr_wdata;
                end
                `ADCSUM_ADDR_SUM3: begin
                    stage3_q <= sfr_wdata;
                end
                default: begin
                    stage1_q <= stage1_q;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // analog front settings
    // ----------------------------------------------------------------
    // both burnout sources follow the one bit, never one alone
    assign open_input_pos_current_en = front_q[`ADCSUM_FRONT_BOD];
    assign open_input_neg_current_en = front_q[`ADCSUM_FRONT_BOD];
    assign internal_reference_enable = front_q[`ADCSUM_FRONT_INTERNAL_REFERENCE_ENABLE];
    assign reference_level_select = front_q[`ADCSUM_FRONT_REFERENCE_LEVEL_SELECT];
    assign input_buffer_enable = front_q[`ADCSUM_FRONT_INPUT_BUFFER_ENABLE];
    assign result_format_select = result_format_q;
    assign settling_select = settling_q;
    assign decim_ratio = {decim_hi_q, decim_lo_q};

    // gain decode is registered, so it trails a write by one cycle
    always @(posedge clk_sys) begin
        if (rst) begin
            gain_factor <= `ADCSUM_GAIN_UNITY;
        end else begin
            gain_factor <= `ADCSUM_GAIN_UNITY << front_q[`ADCSUM_GAIN_HI:`ADCSUM_GAIN_LO];
        end
    end

    // calibration start pulse; reserved codes and zero start nothing
    always @(posedge clk_sys) begin
        if (rst) begin
            calibration_start <= 1'b0;
            calibration_code <= `ADCSUM_CAL_NONE;
        end else begin
            calibration_start <= 1'b0;
            if (wr_fmt && cal_wr != `ADCSUM_CAL_NONE && cal_wr <= `ADCSUM_CAL_LAST) begin
                calibration_start <= 1'b1;
                calibration_code <= cal_wr;
            end
        end
    end

    // ----------------------------------------------------------------
    // output data rate
    // ----------------------------------------------------------------
    // three stages: analog clock divider, fixed oversampling, decimation
    assign aclk_period = {1'b0, analog_clk_div} + 9'h001;

    adcsum_tick_div #(
        .W(9)
    ) u_div_aclk (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(~adc_power_down),
        .period(aclk_period),
        .tick(tick_aclk)
    );

    adcsum_tick_div #(
        .W(7)
    ) u_div_os (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(tick_aclk),
        .period(`ADCSUM_OVERSAMPLE),
        .tick(tick_os)
    );

    adcsum_tick_div #(
        .W(11)
    ) u_div_dec (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(tick_os),
        .period(decim_ratio),
        .tick(conv_tick)
    );

    // ----------------------------------------------------------------
    // result holding
    // ----------------------------------------------------------------
    // unipolar clamps negative input to zero and doubles the step,
    // saturating at full scale rather than wrapping
    assign result_fmt = ~result_format_q ? mod_result :
                        mod_result[23] ? `ADCSUM_UNI_ZERO :
                        mod_result[22] ? `ADCSUM_UNI_FULL :
                        {mod_result[22:0], 1'b0};
    assign capture = mod_result_valid & ~adc_power_down;

    // all three bytes load in one edge, so bytes read between two captures belong to one sample
    always @(posedge clk_sys) begin
        if (rst) begin
            result_q <= 24'h000000;
        end else if (capture) begin
            result_q <= result_fmt;
        end
    end

    // ----------------------------------------------------------------
    // event flags
    // ----------------------------------------------------------------
    // a new event in the clearing cycle keeps the flag set
    always @(posedge clk_sys) begin
        if (rst) begin
            adc_irq_q <= 1'b0;
            sum_pend_q <= 1'b0;
        end else begin
            adc_irq_q <= capture | (adc_irq_q & ~rd_res_lo);
            sum_pend_q <= sum_done | (sum_pend_q & ~rd_sum0);
        end
    end

    // the mask hides the request but not the pending state
    assign adc_irq = adc_irq_q;
    assign sum_irq = sum_pend_q & ~sum_irq_mask;

    // ----------------------------------------------------------------
    // summation unit
    // ----------------------------------------------------------------
    adcsum_accum u_accum (
        .clk_sys(clk_sys),
        .rst(rst),
        .power_down(adc_power_down),
        .mode(ssc_q[`ADCSUM_SSC_MODE_HI:`ADCSUM_SSC_MODE_LO]),
        .cnt_code(ssc_q[`ADCSUM_SSC_CNT_HI:`ADCSUM_SSC_CNT_LO]),
        .shf_code(ssc_q[`ADCSUM_SSC_SHF_HI:`ADCSUM_SSC_SHF_LO]),
        .bipolar(~result_format_q),
        .clear(wr_ssc && sfr_wdata == `ADCSUM_RST_BYTE),
        .shift_go(wr_ssc && sfr_wdata[`ADCSUM_SSC_MODE_HI:`ADCSUM_SSC_MODE_LO]
                  == `ADCSUM_MODE_SHIFT),
        .cpu_add(wr_sum0),
        .cpu_value({stage3_q, stage2_q, stage1_q, sfr_wdata}),
        .adc_add(capture),
        .adc_value(result_fmt),
        .acc(acc),
        .busy(sum_busy),
        .done(sum_done)
    );

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // read mux; calibration field and reserved bits read as zero
    always @* begin
        case (sfr_addr)
            `ADCSUM_ADDR_RES_LO: rdata_d = result_q[7:0];
            `ADCSUM_ADDR_RES_MID: rdata_d = result_q[15:8];
            `ADCSUM_ADDR_RES_HI: rdata_d = result_q[23:16];
            `ADCSUM_ADDR_FRONT: rdata_d = front_q;
            `ADCSUM_ADDR_FMT: rdata_d = {1'b0, result_format_q, settling_q, 4'h0};
            `ADCSUM_ADDR_DEC_LO: rdata_d = decim_lo_q;
            `ADCSUM_ADDR_DEC_HI: rdata_d = {5'h00, decim_hi_q};
            `ADCSUM_ADDR_SSC: rdata_d = ssc_q;
            `ADCSUM_ADDR_SUM0: rdata_d = acc[7:0];
            `ADCSUM_ADDR_SUM1: rdata_d = acc[15:8];
            `ADCSUM_ADDR_SUM2: rdata_d = acc[23:16];
            `ADCSUM_ADDR_SUM3: rdata_d = acc[31:24];
            default: rdata_d = `ADCSUM_RST_BYTE;
        endcase
    end

    // read data is registered and holds until the next read
    always @(posedge clk_sys) begin
        if (rst) begin
            sfr_rdata <= `ADCSUM_RST_BYTE;
        end else if (sfr_rd) begin
            sfr_rdata <= rdata_d;
        end
    end
endmodule

//--- adcsum_sva.sv
// assertion checker for the converter control and summation block
`timescale 1ns/1ps
// ----------------------------------------
// checker
// ----------------------------------------
module adcsum_sva (
    input wire clk_sys,
    input wire rst,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire mod_result_valid,
    input wire adc_power_down,
    input wire sum_irq_mask,
    input wire open_input_pos_current_en,
    input wire open_input_neg_current_en,
    input wire [7:0] gain_factor,
    input wire result_format_select,
    input wire [1:0] settling_select,
    input wire calibration_start,
    input wire [2:0] calibration_code,
    input wire [10:0] decim_ratio,
    input wire adc_irq,
    input wire sum_irq,
    input wire sum_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // write decodes shared by several properties
    wire wr_dc = sfr_wr && (sfr_addr == 8'hdc);
    wire wr_dd = sfr_wr && (sfr_addr == 8'hdd);
    wire cal_ok = (sfr_wdata[2:0] != 3'h0) && (sfr_wdata[2:0] < 3'h6);
    // a shift start must give exactly four busy cycles, then release
    sequence s_go;
        sfr_wr && sfr_addr == 8'he1 && sfr_wdata[7:6] == 2'b10 && !adc_power_down && !sum_busy;
    endsequence
    sequence s_busy4;
        sum_busy [*4] ##1 !sum_busy;
    endsequence
    property p_shift; s_go |=> s_busy4; endproperty
    property p_cap; mod_result_valid && !adc_power_down |=> adc_irq; endproperty
    property p_rdclr;
        sfr_rd && sfr_addr == 8'hd9 && !mod_result_valid |=> !adc_irq;
    endproperty
    property p_bod;
        wr_dc |=> open_input_pos_current_en == $past(sfr_wdata[6])
            && open_input_neg_current_en == $past(sfr_wdata[6]);
    endproperty
    property p_gain; wr_dc |-> ##2 gain_factor == (8'h01 << $past(sfr_wdata[2:0], 2)); endproperty
    property p_fmt;
        wr_dd |=> result_format_select == $past(sfr_wdata[6])
            && settling_select == $past(sfr_wdata[5:4]);
    endproperty
    property p_cal;
        wr_dd && cal_ok |=> calibration_start && calibration_code == $past(sfr_wdata[2:0]);
    endproperty
    property p_nocal; wr_dd && !cal_ok |=> !calibration_start; endproperty
    property p_dec;
        sfr_wr && sfr_addr == 8'hde |=> decim_ratio[7:0] == $past(sfr_wdata);
    endproperty
    property p_mask; sum_irq_mask |-> !sum_irq; endproperty
    a_shift: assert property (p_shift) else $error("shift busy window wrong");
    a_cap: assert property (p_cap) else $error("result flag not set");
    a_rdclr: assert property (p_rdclr) else $error("result flag not cleared");
    a_bod: assert property (p_bod) else $error("open input currents wrong");
    a_gain: assert property (p_gain) else $error("gain decode wrong");
    a_fmt: assert property (p_fmt) else $error("format or settling wrong");
    a_cal: assert property (p_cal) else $error("calibration not started");
    a_nocal: assert property (p_nocal) else $error("spurious calibration");
    a_dec: assert property (p_dec) else $error("ratio low bits wrong");
    a_mask: assert property (p_mask) else $error("masked sum flag seen");
endmodule

bind adcsum_top adcsum_sva u_sva (.*);

//--- adcsum_cpu.sv
// processor core model issuing register bus reads and writes
`timescale 1ns/1ps
module adcsum_cpu (
    input wire clk_sys,
    input wire [7:0] sfr_rdata,
    output logic [7:0] sfr_addr = 8'h00,
    output logic sfr_wr = 1'b0,
    output logic sfr_rd = 1'b0,
    output logic [7:0] sfr_wdata = 8'h00
);
    // strobe for one taking edge; released lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_wr = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    endtask
    // data is sampled one time unit after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        sfr_rd = 1'b0;
        sfr_addr = ~a;
        d = sfr_rdata;
    endtask
endmodule

//--- tb.sv
// self-checking bench for the converter control and summation block
`timescale 1ns/1ps
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] analog_clk_div = 8'h00;
    logic adc_power_down = 1'b0;
    logic sum_irq_mask = 1'b0;
    logic [23:0] mod_result = 24'h000000;
    logic mod_result_valid = 1'b0;
    wire [7:0] sfr_addr, sfr_wdata, sfr_rdata, gain_factor;
    wire sfr_wr, sfr_rd, conv_tick, open_input_pos_current_en, open_input_neg_current_en;
    wire internal_reference_enable, reference_level_select, input_buffer_enable;
    wire result_format_select, adc_irq, sum_irq, sum_busy;
    wire [1:0] settling_select;
    wire [10:0] decim_ratio;
    integer failures = 0;
    integer num_checks = 0;
    integer i;
    integer n;
    logic [7:0] b;
    logic [31:0] v;
    // address and reset value pairs, last one unmapped
    logic [15:0] rv [0:9] = '{16'hd900, 16'hda00, 16'hdb00, 16'hdc30, 16'hdd00,
        16'hde1b, 16'hdf06, 16'he100, 16'he200, 16'he000};

    always #20 clk_sys = ~clk_sys;

    adcsum_cpu cpu (.*);
    adcsum_top dut (.*, .sfr_hit(), .calibration_start(), .calibration_code());

    task automatic conclude;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks = num_checks + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // multi-byte read, lowest address first
    task automatic rdn(input logic [7:0] a, input integer c, output logic [31:0] r);
        logic [7:0] x;
        r = 32'h0;
        for (int k = 0; k < c; k++) begin
            cpu.rd(a + k[7:0], x);
            r[8*k+:8] = x;
        end
    endtask
    task automatic cap(input logic [23:0] d);
        @(posedge clk_sys);
        #1;
        mod_result = d;
        mod_result_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        mod_result_valid = 1'b0;
    endtask
    // bounded poll: 0 busy low, 1 sum flag high, 2 output tick
    task automatic waitfor(input integer s);
        integer t;
        t = 0;
        while (t < 300 && !(s == 0 ? sum_busy === 1'b0 : s == 1 ? sum_irq === 1'b1
                : conv_tick === 1'b1)) begin
            @(posedge clk_sys);
            #1;
            t = t + 1;
        end
        if (t == 300) begin
            chk("wait", 32'h0, 32'h1);
            conclude();
        end
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        cpu.wr(8'hd9, 8'hff);
        for (i = 0; i < 10; i++) begin
            cpu.rd(rv[i][15:8], b);
            chk("reset reg", {24'h0, rv[i][7:0]}, {24'h0, b});
        end
        chk("front pins", 32'h6, {29'h0, internal_reference_enable, reference_level_select,
            input_buffer_enable});
        chk("ratio", 32'h61b, {21'h0, decim_ratio});
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            cpu.wr(8'hdc, {5'h08, i[2:0]});
            @(posedge clk_sys);
            #1;
            chk("gain", 32'h1 << i, {24'h0, gain_factor});
            chk("currents", 32'h3, {30'h0, open_input_pos_current_en,
                open_input_neg_current_en});
        end
        cpu.wr(8'hdc, 8'h30);
        chk("currents off", 32'h0, {30'h0, open_input_pos_current_en,
            open_input_neg_current_en});
        $display("test front done");
        for (i = 0; i < 8; i++) begin
            cpu.wr(8'hdd, {2'b01, i[1:0], 1'b0, i[2:0]});
            cpu.rd(8'hdd, b);
            chk("format reg", {24'h0, 2'b01, i[1:0], 4'h0}, {24'h0, b});
            chk("format pins", {29'h0, 1'b1, i[1:0]}, {29'h0, result_format_select,
                settling_select});
        end
        // unipolar clamps negatives and doubles the step
        cap(24'h800000);
        rdn(8'hd9, 3, v);
        chk("unipolar neg", 32'h0, v);
        cap(24'h001234);
        chk("result flag", 32'h1, {31'h0, adc_irq});
        rdn(8'hd9, 3, v);
        chk("unipolar pos", 32'h002468, v);
        chk("flag cleared", 32'h0, {31'h0, adc_irq});
        cpu.wr(8'hdd, 8'h00);
        cap(24'h812345);
        rdn(8'hd9, 3, v);
        chk("bipolar", 32'h812345, v);
        $display("test result done");
        cpu.wr(8'he1, 8'h00);
        cpu.wr(8'he3, 8'h00);
        cpu.wr(8'he4, 8'h00);
        cpu.wr(8'he5, 8'h80);
        cpu.wr(8'he2, 8'h10);
        cpu.wr(8'he5, 8'h00);
        cpu.wr(8'he2, 8'h08);
        rdn(8'he2, 4, v);
        chk("cpu add", 32'h80000018, v);
        cpu.wr(8'he1, 8'h82);
        waitfor(0);
        rdn(8'he2, 4, v);
        chk("shift", 32'hf0000003, v);
        cpu.wr(8'he1, 8'h00);
        rdn(8'he2, 4, v);
        chk("clear", 32'h0, v);
        $display("test cpu sum done");
        cpu.wr(8'he1, 8'h40);
        cap(24'hfffffe);
        cap(24'h000005);
        waitfor(1);
        sum_irq_mask = 1'b1;
        #1;
        chk("masked", 32'h0, {31'h0, sum_irq});
        sum_irq_mask = 1'b0;
        rdn(8'he2, 4, v);
        chk("adc sum", 32'h3, v);
        chk("sum flag clear", 32'h0, {31'h0, sum_irq});
        cpu.wr(8'he1, 8'h00);
        cpu.wr(8'he1, 8'hc1);
        cap(24'h000010);
        cap(24'h000008);
        waitfor(1);
        rdn(8'he2, 4, v);
        chk("sum shift", 32'h6, v);
        adc_power_down = 1'b1;
        cap(24'h000100);
        rdn(8'he2, 4, v);
        chk("powered down", 32'h0, v);
        adc_power_down = 1'b0;
        $display("test adc sum done");
        cpu.wr(8'hde, 8'h01);
        cpu.wr(8'hdf, 8'h00);
        waitfor(2);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end while (conv_tick !== 1'b1 && n < 200);
        chk("tick period", 32'd64, n);
        $display("test rate done");
        conclude();
    end
endmodule
